// File: core/flash_port_pkg.sv
// constants and carrier types for the nand flash host port
package flash_port_pkg;
	localparam int unsigned CLK_MHZ          = 25;
	localparam int unsigned CYCLE_NS         = 50;
	localparam int unsigned CYCLE_CLKS       = (CYCLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned HALF_CLKS        = (CYCLE_CLKS + 1) / 2;
	localparam int unsigned RANDOM_ACCESS_US = 10;
	localparam int unsigned RANDOM_ACCESS_CLKS = RANDOM_ACCESS_US * CLK_MHZ;
	localparam int unsigned PROG_TYP_US      = 200;
	localparam int unsigned ERASE_TYP_US     = 2000;
	localparam int unsigned BUSY_LIMIT_CLKS  = 4 * ERASE_TYP_US * CLK_MHZ;
	localparam int unsigned PAGE_BYTES       = 528;
	localparam int unsigned PAGE_WORDS       = 264;
	localparam int unsigned BLOCK_BYTES      = 16384;
	localparam int unsigned BLOCK_WORDS      = 8192;
	localparam logic [7:0]  CMD_READ_LOW     = 8'h00;
	localparam logic [7:0]  CMD_READ_HIGH    = 8'h01;
	localparam logic [15:0] RESET_DATA       = 16'h0000;

	typedef enum logic [1:0]
	{
		OP_CMD  = 2'b00,
		OP_ADDR = 2'b01,
		OP_WR   = 2'b10,
		OP_RD   = 2'b11
	} op_kind_t;

	typedef struct packed
	{
		op_kind_t    kind;
		logic        wait_ready;
		logic [15:0] data;
	} req_t;

	typedef struct packed
	{
		logic        chip_sel_n;
		logic        cmd_latch;
		logic        addr_latch;
		logic        write_n;
		logic        read_strobe_n;
		logic        write_prot_n;
	} strobes_t;
endpackage

// File: core/nand_flash_bus_port.sv
// host-side controller that drives the nand flash pins one cycle at a time
`timescale 1ns/10ps
module nand_flash_bus_port
	import flash_port_pkg::*;
#(
	parameter int unsigned BUSY_LIMIT = BUSY_LIMIT_CLKS,
	parameter int unsigned WIDE       = 0
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  clk_en_i,
	input  wire flash_port_pkg::req_t  req_i,
	input  wire logic                  req_valid_i,
	output logic                       req_ready_o,
	input  wire logic                  select_i,
	input  wire logic                  write_enable_i,
	output logic [15:0]                rd_data_o,
	output logic                       rd_valid_o,
	output logic                       timeout_o,
	output flash_port_pkg::strobes_t   pins_o,
	output logic [15:0]                io_out_o,
	output logic [15:0]                io_oe_o,
	input  wire logic [15:0]           io_in_i,
	input  wire logic                  ready_busy_i
);
	import flash_port_pkg::*;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_LOW   = 3'b001,
		ST_HIGH  = 3'b010,
		ST_WAITB = 3'b011,
		ST_WAITR = 3'b100
	} state_t;

	localparam int unsigned CNT_W = $clog2(BUSY_LIMIT + 1) + 1;
	localparam logic [CNT_W-1:0] HALF_CNT  = CNT_W'(HALF_CLKS);
	localparam logic [CNT_W-1:0] RA_CNT    = CNT_W'(RANDOM_ACCESS_CLKS);
	localparam logic [CNT_W-1:0] LIMIT_CNT = CNT_W'(BUSY_LIMIT);

	state_t           state_r;
	state_t           state_nxt;
	req_t             cur_r;
	req_t             cur_w;
	logic [15:0]      lane_w;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             rb_sync;
	logic             take;
	logic             phase_done;
	logic             is_rd;
	logic             is_cmd;
	logic             is_addr;
	logic             drive_bus;
	logic [15:0]      bus_val;
	logic             pulse_low;

	pin_sync #(
		.WIDTH (1)
	) u_rb_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.en_i    (clk_en_i),
		.async_i (ready_busy_i),
		.sync_o  (rb_sync)
	);

	// command and address use only the low byte of a wide bus
	function automatic logic [15:0] lane_mask(input op_kind_t k, input logic [15:0] d);
		lane_mask = (k == OP_CMD || k == OP_ADDR) ? {8'h00, d[7:0]} : d;
	endfunction

	assign take       = (state_r == ST_IDLE) && req_valid_i;
	// request that the pins will carry after this edge
	assign cur_w      = take ? req_i : cur_r;
	assign lane_w     = lane_mask(cur_w.kind, cur_w.data);
	assign phase_done = (cnt_r == '0);
	assign is_rd      = (cur_r.kind == OP_RD);
	assign is_cmd     = (cur_r.kind == OP_CMD);
	assign is_addr    = (cur_r.kind == OP_ADDR);
	assign drive_bus  = (state_nxt == ST_LOW || state_nxt == ST_HIGH)
		&& (cur_w.kind != OP_RD);
	assign bus_val    = WIDE != 0 ? lane_w : {8'h00, lane_w[7:0]};
	assign pulse_low  = (state_nxt == ST_LOW);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = phase_done ? cnt_r : cnt_r - CNT_W'(1);
		case (state_r)
			ST_IDLE:
			begin
				if (take)
				begin
					state_nxt = ST_LOW;
					cnt_nxt   = HALF_CNT;
				end
			end
			ST_LOW:
			begin
				if (phase_done)
				begin
					state_nxt = ST_HIGH;
					cnt_nxt   = HALF_CNT;
				end
			end
			ST_HIGH:
			begin
				if (phase_done)
				begin
					state_nxt = cur_r.wait_ready ? ST_WAITB : ST_IDLE;
					cnt_nxt   = RA_CNT;
				end
			end
			ST_WAITB:
			begin
				// allow busy to show before waiting for ready
				if (!rb_sync || phase_done)
				begin
					state_nxt = ST_WAITR;
					cnt_nxt   = LIMIT_CNT;
				end
			end
			ST_WAITR:
			begin
				if (rb_sync || phase_done)
					state_nxt = ST_IDLE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			cur_r   <= '0;
		end
		else if (clk_en_i)
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			if (take)
				cur_r <= req_i;
		end
	end

	// pins, all registered
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pins_o      <= '{chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
				write_n: 1'b1, read_strobe_n: 1'b1, write_prot_n: 1'b0};
			io_out_o    <= RESET_DATA;
			io_oe_o     <= '0;
			req_ready_o <= 1'b0;
			rd_data_o   <= RESET_DATA;
			rd_valid_o  <= 1'b0;
			timeout_o   <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pins_o.chip_sel_n    <= !select_i;
			pins_o.write_prot_n  <= write_enable_i;
			pins_o.cmd_latch     <= (state_nxt != ST_IDLE) && take ? req_i.kind == OP_CMD
				: (state_nxt == ST_LOW || state_nxt == ST_HIGH) && is_cmd;
			pins_o.addr_latch    <= (state_nxt != ST_IDLE) && take ? req_i.kind == OP_ADDR
				: (state_nxt == ST_LOW || state_nxt == ST_HIGH) && is_addr;
			pins_o.write_n       <= !(pulse_low && (take ? req_i.kind != OP_RD : !is_rd));
			pins_o.read_strobe_n <= !(pulse_low && (take ? req_i.kind == OP_RD : is_rd));
			io_out_o             <= bus_val;
			io_oe_o              <= {16{drive_bus}};
			req_ready_o          <= (state_nxt == ST_IDLE) && !take;
			rd_valid_o           <= (state_r == ST_LOW) && phase_done && is_rd;
			if ((state_r == ST_LOW) && phase_done && is_rd)
				rd_data_o <= WIDE != 0 ? io_in_i : {8'h00, io_in_i[7:0]};
			timeout_o            <= (state_r == ST_WAITR) && phase_done && !rb_sync;
		end
	end
endmodule

// File: core/pin_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             en_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= '0;
			sync_o <= '0;
		end
		else if (en_i)
		begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// File: tb/flash_device_model.sv
// behavioural flash device: command, address, page read
`timescale 1ns/10ps
module flash_device_model
	import flash_port_pkg::*;
(
	input  wire flash_port_pkg::strobes_t pins_i,
	input  wire logic [15:0]              bus_i,
	output logic      [15:0]              bus_o,
	output logic                          ready_busy_o
);
	logic [8:0] col_r;
	logic [7:0] cmd_r;
	initial
	begin
		bus_o = 16'h0000;
		ready_busy_o = 1'b1;
		col_r = 9'h000;
		cmd_r = 8'h00;
	end
	always @(posedge pins_i.write_n)
		if (pins_i.cmd_latch)
			cmd_r <= bus_i[7:0];
		else if (pins_i.addr_latch)
		begin
			col_r <= {cmd_r[0], bus_i[7:0]};
			ready_busy_o <= 1'b0;
			ready_busy_o <= #2000 1'b1;
		end
	always @(negedge pins_i.read_strobe_n)
		if (!pins_i.chip_sel_n)
		begin
			bus_o <= #10 {8'h00, col_r[7:0] ^ {col_r[8], 7'h00}};
			col_r <= col_r + 9'h001;
		end
	always @(posedge pins_i.read_strobe_n or posedge pins_i.chip_sel_n)
		bus_o <= ~bus_o;
endmodule

// File: tb/flash_port_assertions.sv
// pin-level checker for the nand flash host port
`timescale 1ns/10ps
module flash_port_assertions
	import flash_port_pkg::*;
(
	input wire logic                     clock_i,
	input wire logic                     rst_n_i,
	input wire flash_port_pkg::strobes_t pins_o,
	input wire logic [15:0]              io_out_o,
	input wire logic [15:0]              io_oe_o,
	input wire logic                     rd_valid_o,
	input wire logic                     ready_busy_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_end;
		!pins_o.write_n ##1 pins_o.write_n;
	endsequence
	sequence s_rd_cycle;
		!pins_o.read_strobe_n ##1 !pins_o.read_strobe_n ##1 pins_o.read_strobe_n[*2];
	endsequence
	property p_sel_excl;
		!(pins_o.cmd_latch && pins_o.addr_latch);
	endproperty
	property p_rd_quiet;
		!pins_o.read_strobe_n |-> io_oe_o == 16'h0000 && !pins_o.cmd_latch && !pins_o.addr_latch;
	endproperty
	property p_low8;
		!pins_o.write_n && (pins_o.cmd_latch || pins_o.addr_latch)
			|-> io_out_o[15:8] == 8'h00 && io_oe_o[7:0] == 8'hff;
	endproperty
	property p_cmd_hold;
		$fell(pins_o.write_n) && pins_o.cmd_latch
			|=> (pins_o.cmd_latch && $stable(io_out_o)) throughout s_wr_end;
	endproperty
	property p_addr_hold;
		$fell(pins_o.write_n) && pins_o.addr_latch
			|=> (pins_o.addr_latch && $stable(io_out_o)) throughout s_wr_end;
	endproperty
	property p_rd_cycle;
		$fell(pins_o.read_strobe_n) |-> s_rd_cycle;
	endproperty
	property p_rd_sample;
		$rose(pins_o.read_strobe_n) |-> ##[0:1] rd_valid_o;
	endproperty
	property p_wait_ready;
		!ready_busy_i[*4] |-> pins_o.read_strobe_n;
	endproperty
	a_sel_excl: assert property (p_sel_excl) else $error("both latch selects high");
	a_rd_quiet: assert property (p_rd_quiet) else $error("bus busy during read");
	a_low8: assert property (p_low8) else $error("upper lines used");
	a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
	a_addr_hold: assert property (p_addr_hold) else $error("address not held");
	a_rd_cycle: assert property (p_rd_cycle) else $error("read cycle too short");
	a_rd_sample: assert property (p_rd_sample) else $error("read word not taken");
	a_wait_ready: assert property (p_wait_ready) else $error("read while busy");
endmodule
bind nand_flash_bus_port flash_port_assertions u_flash_port_assertions (.clock_i(clock_i),
	.rst_n_i(rst_n_i), .pins_o(pins_o), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
	.rd_valid_o(rd_valid_o), .ready_busy_i(ready_busy_i));

// File: tb/nand_flash_bus_port_tb_top.sv
// self-checking bench for the nand flash host port
`timescale 1ns/10ps
module nand_flash_bus_port_tb_top;
	import flash_port_pkg::*;
	logic        clock_i;
	logic        rst_n_i;
	logic        valid_r;
	logic        sel_r;
	logic        wen_r;
	logic        req_ready;
	logic        rd_valid;
	logic        rb;
	logic        tmo;
	req_t        req_r;
	strobes_t    pins;
	logic [15:0] rd_data;
	logic [15:0] io_out;
	logic [15:0] io_oe;
	logic [15:0] dev_bus;
	logic [15:0] bus_w;
	int          fail_count;
	int          n_checks;
	int          cyc;
	assign bus_w = (|io_oe) ? io_out : dev_bus;
	nand_flash_bus_port #(.BUSY_LIMIT(400), .WIDE(0)) u_nand_flash_bus_port (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .req_i(req_r),
		.req_valid_i(valid_r), .req_ready_o(req_ready), .select_i(sel_r),
		.write_enable_i(wen_r), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .timeout_o(tmo),
		.pins_o(pins), .io_out_o(io_out), .io_oe_o(io_oe), .io_in_i(bus_w),
		.ready_busy_i(rb));
	flash_device_model u_flash_device_model (.pins_i(pins), .bus_i(bus_w),
		.bus_o(dev_bus), .ready_busy_o(rb));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic send(input op_kind_t k, input logic w, input logic [15:0] d);
		for (int n = 0; n < 400 && req_ready !== 1'b1; n++)
			@(posedge clock_i);
		req_r <= '{k, w, d};
		valid_r <= 1'b1;
		@(posedge clock_i);
		valid_r <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic t_read(input logic half, input logic [7:0] col, input int n);
		logic [8:0] a;
		a = {half, col};
		send(OP_CMD, 1'b0, {15'h0000, half});
		send(OP_ADDR, 1'b1, {8'h00, col});
		repeat (n)
		begin
			send(OP_RD, 1'b0, 16'h0000);
			for (int k = 0; k < 8 && rd_valid !== 1'b1; k++)
				@(posedge clock_i);
			check({8'h00, rd_data[7:0]}, {8'h00, a[7:0] ^ {a[8], 7'h00}});
			a = a + 9'h001;
		end
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fail_count++;
			close_out();
		end
	end
	initial
	begin
		rst_n_i = 1'b0;
		valid_r = 1'b0;
		sel_r = 1'b0;
		wen_r = 1'b0;
		req_r = '0;
		fail_count = 0;
		n_checks = 0;
		cyc = 0;
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		sel_r <= 1'b1;
		repeat (3) @(posedge clock_i);
		check({15'h0000, pins.chip_sel_n}, 16'h0000);
		check({15'h0000, pins.write_prot_n}, 16'h0000);
		wen_r <= 1'b1;
		repeat (3) @(posedge clock_i);
		check({15'h0000, pins.write_prot_n}, 16'h0001);
		t_read(1'b0, 8'hfe, 3);
		t_read(1'b1, 8'h10, 2);
		check({15'h0000, tmo}, 16'h0000);
		check({15'h0000, pins.read_strobe_n}, 16'h0001);
		close_out();
	end
endmodule
